// [common/sec_consts.vh]
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH
// serial opcodes, 2 bits after the start bit
`define SEC_OP_READ      2'b10
`define SEC_OP_WRITE     2'b01
`define SEC_OP_ERASE     2'b11
`define SEC_OP_MISC      2'b00
// misc sub-codes in the top two address bits
`define SEC_SUB_LOCK     2'b00
`define SEC_SUB_BULKW    2'b01
`define SEC_SUB_BULKE    2'b10
`define SEC_SUB_UNLOCK   2'b11
// host command codes on nvm_opcode_field
`define SEC_CMD_READ     3'h0
`define SEC_CMD_LOCK     3'h1
`define SEC_CMD_UNLOCK   3'h2
`define SEC_CMD_WRITE    3'h3
`define SEC_CMD_BULKW    3'h4
`define SEC_CMD_ERASE    3'h5
`define SEC_CMD_BULKE    3'h6
`define SEC_CMD_RELOAD   3'h7
// signature location and value
`define SEC_SIG_ADDR     7'h00
`define SEC_SIG_VALUE    8'ha5
// serial clock cycles per command
`define SEC_SHORT_CYC    5'd10
`define SEC_LONG_CYC     5'd18
// timing
`define SEC_CLK_MHZ      200
`define SEC_TIMEOUT_MS   30
`define SEC_TIMEOUT_CYC  (`SEC_TIMEOUT_MS * 1000 * `SEC_CLK_MHZ)
// half period of serial clock in mclk cycles
`define SEC_HALF_DIV     8'd50
`endif

// [core/sec_shifter.v]
`timescale 1ns/100ps
// one serial frame: start bit, opcode, address, optional data, cs held throughout
module sec_shifter (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // control
   input  wire        go,
   input  wire [17:0] frame,
   input  wire [4:0]  nbits,
   input  wire        half_tick,
   input  wire        din_sync,
   // status
   output reg         done,
   output reg  [7:0]  rdata,
   output wire        listen,
   // pins
   output reg         cs,
   output reg         sclk,
   output reg         dout
);
   reg  [17:0] sh_q;
   reg  [4:0]  cnt_q;
   reg         run_q;
   wire [17:0] first_w;
   // data changes on the falling clock so it is settled at the rising one
   assign first_w = frame << (5'd18 - nbits);
   // memory owns the data pin for the last eight clocks of a read
   assign listen = run_q && (cnt_q <= 5'd8);
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sh_q  <= 18'h00000;
         cnt_q <= 5'h00;
         run_q <= 1'b0;
         done  <= 1'b0;
         rdata <= 8'h00;
         cs    <= 1'b0;
         sclk  <= 1'b0;
         dout  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (go && !run_q) begin
            sh_q  <= {first_w[16:0], 1'b0};      // msb first
            dout  <= first_w[17];
            cnt_q <= nbits;
            run_q <= 1'b1;
            cs    <= 1'b1;
         end else if (run_q && half_tick) begin
            if (!sclk) begin
               if (cnt_q == 5'h00) begin
                  run_q <= 1'b0;
                  cs    <= 1'b0;
                  dout  <= 1'b0;
                  done  <= 1'b1;
               end else begin
                  sclk <= 1'b1;
               end
            end else begin
               sclk  <= 1'b0;
               cnt_q <= cnt_q - 5'd1;
               rdata <= {rdata[6:0], din_sync};
               dout  <= sh_q[17];
               sh_q  <= {sh_q[16:0], 1'b0};
            end
         end
      end
   end
endmodule

// [core/sec_top.v]
`timescale 1ns/100ps
`include "sec_consts.vh"
// What this block does
// - after any reset read byte 00h, memory present only if it equals A5h
// - on match read next six bytes into station address bytes 0 to 5
// - after six bytes loaded set the address-loaded status bit
// - on signature mismatch end initialisation, station address left to software
// - host reload repeats check and load; mismatch leaves address-loaded clear
// - host setting busy starts command; busy clears on completion
// - read command leaves fetched byte in data register in the same cycle that busy clears
// - no memory response within 30 ms abandons operation, sets timeout bit
// - interface disabled: clock and data pins become general outputs or internal monitors, chip select held low
// - support single erase and bulk erase commands
// - memory addressed as 128 locations of 8 bits
// - erase, bulk erase, lock, unlock take 10 clocks; others 18
// - successful host reload sets a separate reload-done bit
module sec_top #(
   parameter TIMEOUT_CYC = `SEC_TIMEOUT_CYC
) (
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // host command side
   input  wire        soft_reset,
   input  wire        busy_set,
   input  wire [2:0]  nvm_opcode_field,
   input  wire [6:0]  nvm_location_field,
   input  wire        data_wr,
   input  wire [7:0]  data_wdata,
   // pin mode
   input  wire        if_disable,
   input  wire        gp_sel_monitor,
   input  wire        gp_data_out,
   input  wire        gp_clk_out,
   input  wire        mon_a,
   input  wire        mon_b,
   // status
   output reg         nvm_busy_bit,
   output reg         nvm_timeout_bit,
   output reg         addr_loaded_bit,
   output reg         reload_done_bit,
   output reg  [7:0]  nvm_data_reg,
   output reg  [47:0] station_addr,
   output reg         station_addr_wr,
   // memory pins
   output reg         serial_mem_cs,
   output reg         serial_mem_clock_pin,
   output reg         serial_mem_data_pin_o,
   output reg         serial_mem_data_pin_oe_n,
   input  wire        serial_mem_data_pin_i
);
   localparam ST_IDLE = 6'b000001;
   localparam ST_SIG  = 6'b000010;
   localparam ST_ADDR = 6'b000100;
   localparam ST_CMD  = 6'b001000;
   localparam ST_WAIT = 6'b010000;
   localparam ST_BOOT = 6'b100000;

   reg  [5:0]  st_q;
   reg  [7:0]  div_q;
   reg         tick_q;
   reg  [1:0]  din_q;
   reg  [2:0]  byte_q;
   reg         host_load_q;
   reg         go_q;
   reg  [17:0] frame_q;
   reg  [4:0]  nbits_q;
   reg  [31:0] to_q;
   reg  [2:0]  cmd_q;
   reg  [6:0]  loc_q;
   reg         sent_q;
   wire        done;
   wire [7:0]  rdata;
   wire        cs_w;
   wire        sclk_w;
   wire        dout_w;
   wire        din_s = din_q[1];
   wire        listen_w;
   wire        rd_frame = (nbits_q == `SEC_LONG_CYC) && (frame_q[16:15] == `SEC_OP_READ);

   // serial clock half-period enable
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_q  <= 8'h00;
         tick_q <= 1'b0;
         din_q  <= 2'b00;
      end else begin
         din_q  <= {din_q[0], serial_mem_data_pin_i};
         tick_q <= (div_q == `SEC_HALF_DIV - 8'd1);
         div_q  <= (div_q == `SEC_HALF_DIV - 8'd1) ? 8'h00 : div_q + 8'd1;
      end
   end

   sec_shifter u_shift (
      .mclk      (mclk),
      .rstn      (rstn),
      .go        (go_q),
      .frame     (frame_q),
      .nbits     (nbits_q),
      .half_tick (tick_q),
      .din_sync  (din_s),
      .done      (done),
      .rdata     (rdata),
      .listen    (listen_w),
      .cs        (cs_w),
      .sclk      (sclk_w),
      .dout      (dout_w)
   );

   // pin mux; data pin tristated while reading back
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         serial_mem_cs            <= 1'b0;
         serial_mem_clock_pin     <= 1'b0;
         serial_mem_data_pin_o    <= 1'b0;
         serial_mem_data_pin_oe_n <= 1'b1;
      end else if (if_disable) begin
         serial_mem_cs            <= 1'b0;
         serial_mem_clock_pin     <= gp_sel_monitor ? mon_b : gp_clk_out;
         serial_mem_data_pin_o    <= gp_sel_monitor ? mon_a : gp_data_out;
         serial_mem_data_pin_oe_n <= 1'b0;
      end else begin
         serial_mem_cs            <= cs_w;
         serial_mem_clock_pin     <= sclk_w;
         serial_mem_data_pin_o    <= dout_w;
         serial_mem_data_pin_oe_n <= !(cs_w && !(rd_frame && listen_w));
      end
   end

   // main sequencer
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q            <= ST_BOOT;
         byte_q          <= 3'h0;
         host_load_q     <= 1'b0;
         go_q            <= 1'b0;
         frame_q         <= 18'h00000;
         nbits_q         <= 5'h00;
         to_q            <= 32'h00000000;
         sent_q          <= 1'b0;
         cmd_q           <= 3'h0;
         loc_q           <= 7'h00;
         nvm_busy_bit    <= 1'b1;
         nvm_timeout_bit <= 1'b0;
         addr_loaded_bit <= 1'b0;
         reload_done_bit <= 1'b0;
         nvm_data_reg    <= 8'h00;
         station_addr    <= 48'h000000000000;
         station_addr_wr <= 1'b0;
      end else begin
         go_q            <= 1'b0;
         station_addr_wr <= 1'b0;
         if (data_wr && !nvm_busy_bit)
            nvm_data_reg <= data_wdata;
         if (soft_reset) begin
            st_q         <= ST_BOOT;
            nvm_busy_bit <= 1'b1;
         end else begin
         case (st_q)
         ST_BOOT: begin
            host_load_q     <= 1'b0;
            addr_loaded_bit <= 1'b0;
            st_q            <= ST_SIG;
            go_q            <= 1'b1;
            frame_q         <= {1'b1, `SEC_OP_READ, `SEC_SIG_ADDR, 8'h00};
            nbits_q         <= `SEC_LONG_CYC;
         end
         ST_SIG: if (done) begin
            if (rdata == `SEC_SIG_VALUE) begin
               byte_q  <= 3'h0;
               st_q    <= ST_ADDR;
               go_q    <= 1'b1;
               frame_q <= {1'b1, `SEC_OP_READ, 7'h01, 8'h00};
            end else begin
               st_q         <= ST_IDLE;
               nvm_busy_bit <= 1'b0;
            end
         end
         ST_ADDR: if (done) begin
            station_addr[8*byte_q +: 8] <= rdata;
            if (byte_q == 3'h5) begin
               addr_loaded_bit <= 1'b1;
               reload_done_bit <= host_load_q;
               station_addr_wr <= 1'b1;
               nvm_busy_bit    <= 1'b0;
               st_q            <= ST_IDLE;
            end else begin
               byte_q  <= byte_q + 3'h1;
               go_q    <= 1'b1;
               frame_q <= {1'b1, `SEC_OP_READ, {4'h0, byte_q + 3'h2}, 8'h00};
            end
         end
         ST_IDLE: if (busy_set) begin
            nvm_busy_bit    <= 1'b1;
            nvm_timeout_bit <= 1'b0;
            cmd_q           <= nvm_opcode_field;
            loc_q           <= nvm_location_field;
            st_q            <= ST_CMD;
         end
         ST_CMD: begin
            go_q   <= 1'b1;
            st_q   <= ST_WAIT;
            to_q   <= 32'h00000000;
            sent_q <= 1'b0;
            case (cmd_q)
            `SEC_CMD_READ: begin
               frame_q <= {1'b1, `SEC_OP_READ, loc_q, 8'h00};
               nbits_q <= `SEC_LONG_CYC;
            end
            `SEC_CMD_WRITE: begin
               frame_q <= {1'b1, `SEC_OP_WRITE, loc_q, nvm_data_reg};
               nbits_q <= `SEC_LONG_CYC;
            end
            `SEC_CMD_BULKW: begin
               frame_q <= {1'b1, `SEC_OP_MISC, `SEC_SUB_BULKW, 5'h00, nvm_data_reg};
               nbits_q <= `SEC_LONG_CYC;
            end
            `SEC_CMD_ERASE: begin
               frame_q <= {8'h00, 1'b1, `SEC_OP_ERASE, loc_q};
               nbits_q <= `SEC_SHORT_CYC;
            end
            `SEC_CMD_BULKE: begin
               frame_q <= {8'h00, 1'b1, `SEC_OP_MISC, `SEC_SUB_BULKE, 5'h00};
               nbits_q <= `SEC_SHORT_CYC;
            end
            `SEC_CMD_LOCK: begin
               frame_q <= {8'h00, 1'b1, `SEC_OP_MISC, `SEC_SUB_LOCK, 5'h00};
               nbits_q <= `SEC_SHORT_CYC;
            end
            `SEC_CMD_UNLOCK: begin
               frame_q <= {8'h00, 1'b1, `SEC_OP_MISC, `SEC_SUB_UNLOCK, 5'h00};
               nbits_q <= `SEC_SHORT_CYC;
            end
            default: begin   // reload repeats the boot sequence
               go_q            <= 1'b0;
               st_q            <= ST_SIG;
               host_load_q     <= 1'b1;
               addr_loaded_bit <= 1'b0;
               reload_done_bit <= 1'b0;
               go_q            <= 1'b1;
               frame_q         <= {1'b1, `SEC_OP_READ, `SEC_SIG_ADDR, 8'h00};
               nbits_q         <= `SEC_LONG_CYC;
            end
            endcase
         end
         ST_WAIT: begin
            // write, bulk write, erase and bulk erase wait for the memory to raise its ready level; lock and unlock do not
            if (done && cmd_q == `SEC_CMD_READ) begin
               nvm_data_reg <= rdata;
               nvm_busy_bit <= 1'b0;
               st_q         <= ST_IDLE;
            end else if (done) begin
               sent_q <= 1'b1;
            end else if (sent_q) begin
               // first samples still carry the level from inside the frame
               if (to_q >= 32'd3 &&
                   (din_s || cmd_q == `SEC_CMD_LOCK || cmd_q == `SEC_CMD_UNLOCK)) begin
                  sent_q       <= 1'b0;
                  nvm_busy_bit <= 1'b0;
                  st_q         <= ST_IDLE;
               end else if (to_q == TIMEOUT_CYC - 1) begin
                  sent_q          <= 1'b0;
                  nvm_timeout_bit <= 1'b1;
                  nvm_busy_bit    <= 1'b0;
                  st_q            <= ST_IDLE;
               end else
                  to_q <= to_q + 32'd1;
            end
         end
         default: st_q <= ST_IDLE;
         endcase
         end
      end
   end
endmodule

// [sim/sec_top_checker.sv]
`timescale 1ns/100ps
module sec_top_checker (
   // clock and reset
   input wire        mclk,
   input wire        rstn,
   // host side
   input wire        busy_set,
   input wire        data_wr,
   input wire        if_disable,
   // status
   input wire        nvm_busy_bit,
   input wire        nvm_timeout_bit,
   input wire        reload_done_bit,
   input wire        addr_loaded_bit,
   input wire [7:0]  nvm_data_reg,
   input wire [47:0] station_addr,
   input wire        station_addr_wr,
   // pins
   input wire        serial_mem_cs,
   input wire        serial_mem_clock_pin,
   input wire        serial_mem_data_pin_oe_n
);
   reg [11:0] cs_len_q;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rstn);
   always @(posedge mclk or negedge rstn) begin
      if (!rstn)
         cs_len_q <= 12'h000;
      else if (serial_mem_cs)
         cs_len_q <= cs_len_q + 12'h001;
      else
         cs_len_q <= 12'h000;
   end
   a_busy_start: assert property (busy_set && !nvm_busy_bit |-> ##[1:2] nvm_busy_bit)
      else $error("busy did not rise after start");
   a_cs_busy: assert property (serial_mem_cs && !if_disable |-> nvm_busy_bit)
      else $error("frame outside a busy period");
   // 10 or 18 serial clocks of 100 mclk, plus up to one half tick before the first
   a_frame_len: assert property ($fell(serial_mem_cs) && !if_disable |->
      (cs_len_q >= 12'd1001 && cs_len_q <= 12'd1050) ||
      (cs_len_q >= 12'd1801 && cs_len_q <= 12'd1850))
      else $error("frame length out of range");
   a_idle_release: assert property (!serial_mem_cs && !if_disable && !$past(if_disable) |->
      serial_mem_data_pin_oe_n) else $error("data pin driven outside a frame");
   a_clk_low_sel: assert property ($rose(serial_mem_cs) && !if_disable |->
      !serial_mem_clock_pin) else $error("serial clock high at select");
   a_load_flag: assert property (station_addr_wr |-> ##[0:1] addr_loaded_bit)
      else $error("loaded bit missing after address load");
   a_load_pulse: assert property (station_addr_wr |=> !station_addr_wr)
      else $error("address load pulse too long");
   a_tmo_ends: assert property ($rose(nvm_timeout_bit) |-> ##[0:2] !nvm_busy_bit)
      else $error("busy held after timeout");
   a_data_src: assert property ($changed(nvm_data_reg) |->
      $past(nvm_busy_bit) || $past(data_wr)) else $error("data changed without cause");
   a_addr_busy: assert property ($changed(station_addr) |-> $past(nvm_busy_bit))
      else $error("address changed while idle");
   cover property ($rose(nvm_timeout_bit));
   cover property (station_addr_wr);
   cover property ($rose(reload_done_bit));
endmodule
bind sec_top sec_top_checker sec_top_checker_i (.mclk, .rstn, .busy_set, .data_wr,
   .if_disable, .nvm_busy_bit, .nvm_timeout_bit, .reload_done_bit, .addr_loaded_bit,
   .nvm_data_reg, .station_addr, .station_addr_wr, .serial_mem_cs, .serial_mem_clock_pin,
   .serial_mem_data_pin_oe_n);

// [sim/sec_mem_model.sv]
`timescale 1ns/100ps
module sec_mem_model #(
   parameter BUSY_NS = 500
) (
   // serial pins
   input  wire cs,
   input  wire sclk,
   input  wire di,
   output reg  do_o,
   // fault control
   input  wire mute,
   output reg  frame_err
);
   reg [7:0]  mem [0:127];
   reg [17:0] sh;
   reg [4:0]  n;
   reg [1:0]  op;
   reg [6:0]  ad;
   reg        wen;
   integer    i;
   initial begin
      wen = 1'b0;
      do_o = 1'b0;
      frame_err = 1'b0;
      n = 5'd0;
      for (i = 0; i < 128; i = i + 1)
         mem[i] = 8'hff;
   end
   always @(posedge cs)
      n = 5'd0;
   // undriven phases toggle so a stale level is never mistaken for data
   always @(posedge sclk) begin
      if (cs) begin
         sh = {sh[16:0], di};
         n = n + 5'd1;
         if (n == 5'd10) begin
            op = sh[8:7];
            ad = sh[6:0];
            frame_err = frame_err | ~sh[9];
         end
         do_o = (n > 5'd10 && op == 2'b10) ? mem[ad][5'd18 - n] : ~do_o;
      end
   end
   always @(negedge cs) begin
      if (n > 5'd0) begin
         frame_err = frame_err | (n != ((op == 2'b10 || op == 2'b01 ||
            (op == 2'b00 && ad[6:5] == 2'b01)) ? 5'd18 : 5'd10));
         if (op == 2'b00 && ad[6] == ad[5])
            wen = ad[6];
         else if (op != 2'b10 && wen) begin
            for (i = 0; i < 128; i = i + 1)
               if (op == 2'b00 || i == ad)
                  mem[i] = (op == 2'b11 || (op == 2'b00 && ad[6])) ? 8'hff : sh[7:0];
            do_o = 1'b0;
            #(BUSY_NS);
            do_o = ~mute;
         end else if (op != 2'b10)
            do_o = 1'b1;
      end
   end
endmodule

// [sim/sec_top_bench.sv]
`timescale 1ns/100ps
`include "sec_consts.vh"
module sec_top_bench;
   reg         mclk, rstn, soft_reset, busy_set, data_wr, if_disable, gp_d, gp_c, mute;
   reg         gp_sel, mon_a, mon_b;
   reg  [2:0]  op;
   reg  [6:0]  loc;
   reg  [7:0]  wdata;
   wire        busy, tmo, loaded, rdone, cs, sck, dq_o, dq_oe_n, mem_do, frame_err;
   wire [7:0]  rdata;
   wire [47:0] saddr;
   wire        dq = dq_oe_n ? mem_do : dq_o;
   integer     error_cnt, checks_done, k;
`define CHK(a, b, m) begin checks_done = checks_done + 1; if ((a) !== (b)) begin \
   error_cnt = error_cnt + 1; $display("CHECK FAILED at %0t: %s", $time, m); end end
   sec_top #(.TIMEOUT_CYC(2000)) sec_top_i (
      .mclk(mclk), .rstn(rstn), .soft_reset(soft_reset), .busy_set(busy_set),
      .nvm_opcode_field(op), .nvm_location_field(loc), .data_wr(data_wr), .data_wdata(wdata),
      .if_disable(if_disable), .gp_sel_monitor(gp_sel), .gp_data_out(gp_d), .gp_clk_out(gp_c),
      .mon_a(mon_a), .mon_b(mon_b), .nvm_busy_bit(busy), .nvm_timeout_bit(tmo),
      .addr_loaded_bit(loaded), .reload_done_bit(rdone), .nvm_data_reg(rdata),
      .station_addr(saddr), .station_addr_wr(), .serial_mem_cs(cs), .serial_mem_clock_pin(sck),
      .serial_mem_data_pin_o(dq_o), .serial_mem_data_pin_oe_n(dq_oe_n), .serial_mem_data_pin_i(dq));
   sec_mem_model #(.BUSY_NS(500)) sec_mem_model_i (.cs(cs), .sclk(sck), .di(dq), .do_o(mem_do),
      .mute(mute), .frame_err(frame_err));
   task wait_idle;
      begin
         k = 0;
         while (busy !== 1'b0 && k < 30000) begin
            @(negedge mclk);
            k = k + 1;
         end
         `CHK(busy, 1'b0, "busy never cleared")
      end
   endtask
   task cmd(input [2:0] c, input [6:0] a, input [7:0] d);
      begin
         @(negedge mclk);
         data_wr = 1'b1;
         wdata = d;
         @(negedge mclk);
         data_wr = 1'b0;
         op = c;
         loc = a;
         busy_set = 1'b1;
         @(negedge mclk);
         busy_set = 1'b0;
         @(negedge mclk);
         `CHK(busy, 1'b1, "command not started")
         wait_idle;
      end
   endtask
   task rd(input [6:0] a, input [7:0] e);
      begin
         cmd(`SEC_CMD_READ, a, 8'h00);
         `CHK(rdata, e, "read data")
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", checks_done, error_cnt);
         if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #450000;
      error_cnt = error_cnt + 1;
      print_verdict;
   end
   initial begin
      {rstn, soft_reset, busy_set, data_wr, if_disable, gp_d, gp_c, mute} = 8'h00;
      {gp_sel, mon_a, mon_b} = 3'h0;
      {op, loc, wdata} = 18'h00000;
      error_cnt = 0;
      checks_done = 0;
      repeat (5) @(negedge mclk);
      for (k = 0; k < 7; k = k + 1)
         sec_mem_model_i.mem[k] = (k == 0) ? `SEC_SIG_VALUE : 8'h11 * k[7:0];
      rstn = 1'b1;
      wait_idle;
      `CHK({loaded, rdone, saddr}, {2'b10, 48'h665544332211}, "boot")
      rd(7'h03, 8'h33);
      rd(7'h7f, 8'hff);
      cmd(`SEC_CMD_WRITE, 7'h7f, 8'h5a);
      rd(7'h7f, 8'hff);
      cmd(`SEC_CMD_UNLOCK, 7'h00, 8'h00);
      cmd(`SEC_CMD_WRITE, 7'h7f, 8'h5a);
      rd(7'h7f, 8'h5a);
      cmd(`SEC_CMD_ERASE, 7'h7f, 8'h00);
      rd(7'h7f, 8'hff);
      cmd(`SEC_CMD_BULKE, 7'h00, 8'h00);
      rd(7'h03, 8'hff);
      soft_reset = 1'b1;
      @(negedge mclk);
      soft_reset = 1'b0;
      @(negedge mclk);
      `CHK(busy, 1'b1, "soft reset load")
      wait_idle;
      `CHK(saddr, 48'h665544332211, "address kept")
      cmd(`SEC_CMD_RELOAD, 7'h00, 8'h00);
      `CHK(rdone, 1'b0, "failed reload")
      cmd(`SEC_CMD_BULKW, 7'h00, 8'h3c);
      cmd(`SEC_CMD_WRITE, `SEC_SIG_ADDR, `SEC_SIG_VALUE);
      cmd(`SEC_CMD_RELOAD, 7'h00, 8'h00);
      `CHK({rdone, saddr}, {1'b1, {6{8'h3c}}}, "reload")
      mute = 1'b1;
      cmd(`SEC_CMD_WRITE, 7'h02, 8'h00);
      `CHK(tmo, 1'b1, "timeout")
      mute = 1'b0;
      cmd(`SEC_CMD_LOCK, 7'h00, 8'h00);
      `CHK({tmo, frame_err}, 2'b00, "lock or framing")
      if_disable = 1'b1;
      for (k = 0; k < 8; k = k + 1) begin
         {gp_sel, gp_d, gp_c} = k[2:0];
         {mon_a, mon_b} = ~k[1:0];
         repeat (4) @(negedge mclk);
         `CHK({dq_o, sck, dq_oe_n}, {k[2] ? ~k[1:0] : k[1:0], 1'b0}, "general outputs")
      end
      print_verdict;
   end
endmodule
